// ### verification/cpa_cache_maint_chk.sv
/* Concurrent checks on the ports of the cache maintenance block.
   Assumes one clock and a synchronous active-low reset; bound to every instance. */
`timescale 1ns/1ps
module cpa_cache_maint_chk
   import cpa_pkg::*;
(
   input wire logic        i_core_clk,
   input wire logic        i_rstn,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [3:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        i_cb_req,
   input wire logic        i_cb_we,
   input wire logic [31:0] i_cb_addr,
   input wire logic [1:0]  i_cb_size,
   input wire logic        i_cb_tset,
   input wire logic        o_cb_ack,
   input wire logic        o_cb_err,
   input wire logic        o_cb_hit,
   input wire logic        o_cb_fill,
   input wire logic        o_cb_bypass,
   input wire logic [1:0]  o_cb_way,
   input wire logic        o_cache_en,
   input wire logic        o_two_way
);
   // Decoded takes on both buses.
   wire       wb_take = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire       ctl_wr  = wb_take && i_wb_we && i_wb_adr == CPA_OFS_CTL && i_wb_sel[0];
   wire [2:0] rgn     = i_cb_addr[31:29];
   wire       apurge  = i_cb_we && rgn == CPA_RGN_APURGE;
   wire       aa      = rgn == CPA_RGN_ADDRARR;

   default clocking dclk @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   chk_reset_off: assert property (disable iff (1'b0) !i_rstn |=> !o_cache_en && !o_two_way)
      else $error("control bits not cleared by reset");
   chk_ctl_apply: assert property (ctl_wr |=> o_cache_en == $past(i_wb_dat[CPA_CTL_EN])
      && o_two_way == $past(i_wb_dat[CPA_CTL_TWM]))
      else $error("control write not applied");
   chk_wb_answer: assert property (wb_take |=> o_wb_ack)
      else $error("register access not answered in one cycle");
   chk_cb_answer: assert property ($rose(i_cb_req) && !apurge |=> o_cb_ack ##1 !o_cb_ack)
      else $error("cache bus access not answered in one cycle");
   chk_purge_two: assert property ($rose(i_cb_req) && apurge |=> !o_cb_ack ##1 o_cb_ack)
      else $error("associative purge not two cycles");
   chk_aa_refuse: assert property ($rose(i_cb_req) && aa && i_cb_size != CPA_SZ_LONG |=> o_cb_err)
      else $error("short address array access not refused");
   chk_aa_long: assert property ($rose(i_cb_req) && aa && i_cb_size == CPA_SZ_LONG |=> !o_cb_err)
      else $error("longword address array access refused");
   chk_err_ack: assert property (o_cb_err |-> o_cb_ack)
      else $error("error without acknowledge");
   chk_tset_bypass: assert property ($rose(i_cb_req) && i_cb_tset && !i_cb_we && rgn == CPA_RGN_CACHED
      && o_cache_en |=> o_cb_bypass && !o_cb_hit && !o_cb_fill)
      else $error("test-and-set read not bypassed");
   chk_two_way_vic: assert property (o_cb_ack && o_cb_fill && o_two_way |-> o_cb_way[1])
      else $error("two-way fill into ways 0 or 1");

   // Main scenarios reached.
   cov_purge: cover property ($rose(i_cb_req) && apurge);
   cov_refuse: cover property (o_cb_err);
   cov_tw_fill: cover property (o_cb_ack && o_cb_fill && o_two_way);
endmodule

bind cpa_cache_maint cpa_cache_maint_chk cpa_cache_maint_chk_i (.i_core_clk, .i_rstn, .i_wb_cyc,
   .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .i_cb_req, .i_cb_we, .i_cb_addr,
   .i_cb_size, .i_cb_tset, .o_cb_ack, .o_cb_err, .o_cb_hit, .o_cb_fill, .o_cb_bypass, .o_cb_way,
   .o_cache_en, .o_two_way);

// ### verification/cpa_cpu_model.sv
/* Model of the CPU core on the cache bus: one request at a time.
   Assumes the block answers with a one-cycle acknowledge on the shared clock. */
`timescale 1ns/1ps
module cpa_cpu_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_cb_ack,
   input  wire logic        i_cb_err,
   output logic             o_cb_req,
   output logic             o_cb_we,
   output logic      [31:0] o_cb_addr,
   output logic      [1:0]  o_cb_size,
   output logic      [31:0] o_cb_wdata,
   output logic             o_cb_ifetch,
   output logic             o_cb_tset
);
   // Idle bus at time zero.
   initial
   begin
      o_cb_req = 1'b0;
      o_cb_we = 1'b0;
      o_cb_addr = 32'h0000_0000;
      o_cb_size = 2'h0;
      o_cb_wdata = 32'h0000_0000;
      o_cb_ifetch = 1'b0;
      o_cb_tset = 1'b0;
   end

   // One request, held until the acknowledge; lat is cycles from take to answer, 99 on timeout.
   task automatic access(input logic w, input logic [31:0] a, input logic [1:0] z, input logic [31:0] d,
                         input logic f, input logic t, output int lat, output logic e);
      int n;
      @(posedge i_core_clk);
      o_cb_req <= 1'b1;
      o_cb_we <= w;
      o_cb_addr <= a;
      o_cb_size <= z;
      o_cb_wdata <= d;
      o_cb_ifetch <= f;
      o_cb_tset <= t;
      n = 0;
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (i_cb_ack !== 1'b1 && n < 50);
      e = i_cb_err;
      lat = (n < 50) ? n - 1 : 99;
      o_cb_req <= 1'b0;
      o_cb_addr <= ~a;  // Released address and data lines show the inverse of their last value.
      o_cb_wdata <= ~d;
   endtask
endmodule

// ### verification/tb_top.sv
/* Self-checking bench for the cache maintenance block.
   Assumes the CPU model drives the cache bus; tasks here drive the register bus. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top
   import cpa_pkg::*;
;
   logic        i_core_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we;
   logic [3:0]  i_wb_adr, i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat, i_cb_addr, i_cb_wdata, o_cb_rdata, rd;
   logic        o_wb_ack, i_cb_req, i_cb_we, i_cb_ifetch, i_cb_tset, o_cb_ack, o_cb_err;
   logic        o_cb_hit, o_cb_fill, o_cb_bypass, o_cache_en, o_two_way, er;
   logic [1:0]  i_cb_size, o_cb_way;
   int          failures, tests_run, lat;

   cpa_cache_maint cpa_cache_maint_i (.i_core_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
      .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_cb_req, .i_cb_we, .i_cb_addr, .i_cb_size, .i_cb_wdata,
      .i_cb_ifetch, .i_cb_tset, .o_cb_ack, .o_cb_err, .o_cb_rdata, .o_cb_hit, .o_cb_fill, .o_cb_bypass,
      .o_cb_way, .o_cache_en, .o_two_way);
   cpa_cpu_model cpa_cpu_model_i (.i_core_clk, .i_cb_ack(o_cb_ack), .i_cb_err(o_cb_err),
      .o_cb_req(i_cb_req), .o_cb_we(i_cb_we), .o_cb_addr(i_cb_addr), .o_cb_size(i_cb_size),
      .o_cb_wdata(i_cb_wdata), .o_cb_ifetch(i_cb_ifetch), .o_cb_tset(i_cb_tset));

   // Free-running 100 MHz clock.
   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   task automatic end_sim;
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One classic Wishbone cycle, held until acknowledge.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge i_core_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_sel <= 4'hF;
      i_wb_adr <= a;
      i_wb_dat <= d;
      n = 0;
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (o_wb_ack !== 1'b1 && n < 50);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      if (n == 50)
      begin
         failures++;
         end_sim;
      end
   endtask

   task automatic ctl(input logic [7:0] v);
      wb(1'b1, CPA_OFS_CTL, {24'h00_0000, v});
   endtask

   task automatic cbus(input logic w, input logic [31:0] a, input logic [1:0] z, input logic [31:0] d,
                       input logic f, input logic t);
      cpa_cpu_model_i.access(w, a, z, d, f, t, lat, er);
      if (lat == 99)
      begin
         failures++;
         end_sim;
      end
   endtask

   // Cached address with the given tag at entry 1.
   function automatic logic [31:0] tg(input int t);
      return {3'h0, t[18:0], 6'h01, 4'h0};
   endfunction

   task automatic t_reset;
      `CHK("en", 1'b0, o_cache_en)
      wb(1'b0, CPA_OFS_CTL, 32'h0000_0000);
      `CHK("ctl", 32'h0000_0000, rd)
      wb(1'b1, 4'h8, 32'h0000_00FF);
      wb(1'b0, 4'h8, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rd)
      $display("t_reset done");
   endtask

   task automatic t_purge;
      ctl(8'h10);
      wb(1'b0, CPA_OFS_CTL, 32'h0000_0000);
      `CHK("purge clears", 1'b0, rd[CPA_CTL_PRG])
      for (int w = 0; w < 4; w++)
      begin
         ctl({w[1:0], 6'h00});
         cbus(1'b0, 32'h6000_03F0, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
         `CHK("valid", 1'b0, o_cb_rdata[CPA_AVALID_BIT])
         `CHK("lru", 6'h00, o_cb_rdata[9:4])
      end
      $display("t_purge done");
   endtask

   task automatic t_data;
      logic [31:0] ex;
      for (int w = 0; w < 4; w++)
         cbus(1'b1, {20'hC0000, w[1:0], 10'h010}, CPA_SZ_LONG, 32'h1122_3300 + w, 1'b0, 1'b0);
      cbus(1'b1, 32'hC000_0811, CPA_SZ_BYTE, 32'h00AA_0000, 1'b0, 1'b0);
      cbus(1'b1, 32'hC000_0812, CPA_SZ_WORD, 32'h0000_BBCC, 1'b0, 1'b0);
      `CHK("wr lat", 1, lat)
      for (int w = 0; w < 4; w++)
      begin
         ex = (w == 2) ? 32'h11AA_BBCC : 32'h1122_3300 + w;
         cbus(1'b0, {20'hC0000, w[1:0], 10'h010}, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
         `CHK("ram rd", ex, o_cb_rdata)
         `CHK("rd lat", 1, lat)
      end
      $display("t_data done");
   endtask

   task automatic t_fill;
      ctl(8'h01);
      for (int i = 0; i < 5; i++)
      begin
         cbus(1'b0, tg(i + 1), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
         `CHK("fill", 1'b1, o_cb_fill)
         `CHK("victim", 2'(3 - i), o_cb_way)
      end
      cbus(1'b0, tg(2), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("hit way", 3'h6, {o_cb_hit, o_cb_way})
      $display("t_fill done");
   endtask

   task automatic t_assoc;
      cbus(1'b1, tg(3) + 32'h4000_0000, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("purge lat", 2, lat)
      cbus(1'b1, tg(9) + 32'h4000_0000, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      cbus(1'b0, tg(4), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("kept way0", 3'h4, {o_cb_hit, o_cb_way})
      cbus(1'b0, tg(3), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("purged miss", 4'h5, {o_cb_hit, o_cb_fill, o_cb_way})
      cbus(1'b0, tg(2), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b1);
      `CHK("tset", 2'h1, {o_cb_hit, o_cb_bypass})
      $display("t_assoc done");
   endtask

   task automatic t_fill_off;
      ctl(8'h00);
      ctl(8'h04);
      ctl(8'h05);
      cbus(1'b0, tg(7), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("dfill miss", 2'h0, {o_cb_hit, o_cb_fill})
      cbus(1'b0, tg(2), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("dfill hit", 1'b1, o_cb_hit)
      cbus(1'b0, tg(8), CPA_SZ_LONG, 32'h0000_0000, 1'b1, 1'b0);
      `CHK("dfill fetch", 1'b1, o_cb_fill)
      ctl(8'h00);
      ctl(8'h02);
      ctl(8'h03);
      cbus(1'b0, tg(10), CPA_SZ_LONG, 32'h0000_0000, 1'b1, 1'b0);
      `CHK("ifill fetch", 1'b0, o_cb_fill)
      ctl(8'h00);
      $display("t_fill_off done");
   endtask

   task automatic t_addr_arr;
      ctl(8'h40);
      cbus(1'b1, {3'h3, 19'h5_A5A5, 6'h05, 4'h4}, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      cbus(1'b0, 32'h6000_0050, CPA_SZ_WORD, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("short err", 1'b1, er)
      cbus(1'b0, 32'h6000_0050, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("aa tag", 19'h5_A5A5, o_cb_rdata[28:10])
      `CHK("aa lru v", 7'h01, {o_cb_rdata[9:4], o_cb_rdata[2]})
      ctl(8'h80);
      cbus(1'b0, 32'h6000_0050, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("other way", 1'b0, o_cb_rdata[2])
      $display("t_addr_arr done");
   endtask

   task automatic t_two_way;
      ctl(8'h10);
      ctl(8'h09);
      `CHK("two", 1'b1, o_two_way)
      cbus(1'b0, tg(11), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("two first", 2'h3, o_cb_way)
      cbus(1'b0, tg(12), CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("two second", 2'h2, o_cb_way)
      cbus(1'b1, 32'hC000_0404, CPA_SZ_LONG, 32'hCAFE_0001, 1'b0, 1'b0);
      cbus(1'b0, 32'hC000_0404, CPA_SZ_LONG, 32'h0000_0000, 1'b0, 1'b0);
      `CHK("two ram", 32'hCAFE_0001, o_cb_rdata)
      $display("t_two_way done");
   endtask

   // Reset, then every scenario in turn.
   initial
   begin
      failures = 0;
      tests_run = 0;
      i_rstn = 1'b0;
      i_wb_cyc = 1'b0;
      i_wb_stb = 1'b0;
      i_wb_we = 1'b0;
      i_wb_adr = 4'h0;
      i_wb_sel = 4'hF;
      i_wb_dat = 32'h0000_0000;
      repeat (12) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      t_reset;
      t_purge;
      t_data;
      t_fill;
      t_assoc;
      t_fill_off;
      t_addr_arr;
      t_two_way;
      end_sim;
   end
endmodule

// ### verilog/cpa_cache_maint.sv
/*
 * Cache maintenance and direct array access for a four-way, 64-entry,
 * 16-byte-line write-through cache: tag, valid and pseudo-LRU state, victim
 * choice, full purge, associative purge and mapped access to both arrays.
 * Assumes the CPU cache bus and the Wishbone master share i_core_clk, and that
 * the CPU holds a request until it sees o_cb_ack.
 */
// Behaviour
// - Victim way chosen from six LRU bits.
// - Purge bit clears all valid and LRU.
// - Fetches keep being served during register writes.
// - Reset clears the cache enable bit.
// - Write to target plus offset invalidates entry.
// - Associative purge hits one line, two cycles.
// - All four tags compared; no match, no change.
// - Data array byte/word/long, one cycle each.
// - Data array uses the cache bus only.
// - Each way's data is a 1-kbyte window.
// - Data window doubles as on-chip RAM.
// - Address array mapped once, way from control.
// - Address array read returns tag, LRU, valid.
// - Address array write: tag/valid from address.
// - Reset leaves arrays untouched.
// - Two-way mode: ways 0,1 RAM; 2,3 cache.
// - Two-way fill order way 3 then 2.
// - Data-fill disable: allocate on fetches only.
// - Test-and-set reads always bypass the cache.
// - Every hit or refill updates LRU bits.
// - Fill disable: miss passes through, no replace.
`timescale 1ns/1ps
module cpa_cache_maint
   import cpa_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_cb_req,
   input  wire logic        i_cb_we,
   input  wire logic [31:0] i_cb_addr,
   input  wire logic [1:0]  i_cb_size,
   input  wire logic [31:0] i_cb_wdata,
   input  wire logic        i_cb_ifetch,
   input  wire logic        i_cb_tset,
   output logic             o_cb_ack,
   output logic             o_cb_err,
   output logic      [31:0] o_cb_rdata,
   output logic             o_cb_hit,
   output logic             o_cb_fill,
   output logic             o_cb_bypass,
   output logic      [1:0]  o_cb_way,
   output logic             o_cache_en,
   output logic             o_two_way
);

   // Big-endian byte lanes for one access; lane 3 holds bits 31..24.
   function automatic logic [3:0] cpa_lanes(input logic [1:0] sz, input logic [1:0] a);
      logic [3:0] m;
      m = 4'hF;
      if (sz == CPA_SZ_BYTE)
      begin
         m = 4'h8 >> a;
      end
      else if (sz == CPA_SZ_WORD)
      begin
         m = a[1] ? 4'h3 : 4'hC;
      end
      return m;
   endfunction

   // Way to replace; two-way mode only chooses between ways 2 and 3.
   function automatic logic [1:0] cpa_victim(input logic [5:0] l, input logic tw);
      logic [1:0] v;
      v = 2'h3;
      if (tw)
      begin
         v = l[0] ? 2'h2 : 2'h3;
      end
      else if (l[5] & l[4] & l[3])
      begin
         v = 2'h0;
      end
      else if (!l[5] & l[2] & l[1])
      begin
         v = 2'h1;
      end
      else if (!l[4] & !l[2] & l[0])
      begin
         v = 2'h2;
      end
      return v;
   endfunction

   // New LRU bits after an access to one way; untouched bits hold.
   function automatic logic [5:0] cpa_lru_upd(input logic [5:0] l, input logic [1:0] w);
      logic [5:0] n;
      n = l;
      case (w)
         2'h0: n = {3'h0, l[2:0]};
         2'h1: n = {1'b1, l[4:3], 2'h0, l[0]};
         2'h2: n = {l[5], 1'b1, l[3], 1'b1, l[1], 1'b0};
         default: n = {l[5:4], 1'b1, l[2], 2'h3};
      endcase
      return n;
   endfunction

   // Arrays; none of them is cleared by reset.
   logic [CPA_TAG_W-1:0] tag_mem  [0:CPA_WAYS-1][0:CPA_ENTRIES-1];
   logic [31:0]          data_mem [0:CPA_WAYS*CPA_WAYWORDS-1];
   logic [CPA_ENTRIES-1:0] valid_q [0:CPA_WAYS-1];
   logic [CPA_ENTRIES-1:0] valid_d [0:CPA_WAYS-1];
   logic [CPA_LRU_W-1:0]   lru_q   [0:CPA_ENTRIES-1];
   logic [CPA_LRU_W-1:0]   lru_d   [0:CPA_ENTRIES-1];

   cpa_state_t     state_q;
   cpa_state_t     state_d;
   logic [31:0]    pur_addr_q;
   logic [31:0]    pur_addr_d;
   logic           cb_ack_q, cb_ack_d;
   logic           cb_err_q, cb_err_d;
   logic [31:0]    cb_rdata_q, cb_rdata_d;
   logic           cb_hit_q, cb_hit_d;
   logic           cb_fill_q, cb_fill_d;
   logic           cb_bypass_q, cb_bypass_d;
   logic [1:0]     cb_way_q, cb_way_d;
   logic [7:0]     ctl_q, ctl_d;
   logic           wb_ack_q, wb_ack_d;
   logic [31:0]    wb_dat_q, wb_dat_d;

   logic           tag_we;
   logic [1:0]     tag_way;
   logic [5:0]     tag_idx;
   logic [CPA_TAG_W-1:0] tag_wdata;
   logic [3:0]     dat_we;
   logic [9:0]     dat_idx;

   logic [31:0]    look_addr;
   logic [5:0]     look_idx;
   logic [3:0]     hit_vec;
   logic [1:0]     hit_way;
   logic           purge_all;
   logic           take;

   // The purge compare uses the held target; all other lookups the live address.
   assign look_addr = (state_q == CPA_ST_PURGE) ? pur_addr_q : i_cb_addr;
   assign look_idx  = look_addr[CPA_IDX_LSB +: 6];
   assign take      = i_cb_req & ~cb_ack_q & (state_q == CPA_ST_IDLE);
   assign dat_idx   = {i_cb_addr[11:10], i_cb_addr[9:2]};

   // One comparator per way, all working in the same cycle.
   genvar gw;
   generate
      for (gw = 0; gw < CPA_WAYS; gw++)
      begin : g_cmp
         assign hit_vec[gw] = valid_q[gw][look_idx] &
                              (tag_mem[gw][look_idx] == look_addr[31-3:CPA_TAG_LSB]);
      end
   endgenerate

   // Encoded hitting way; with sane contents at most one way matches.
   always_comb
   begin
      hit_way = 2'h0;
      for (int w = 0; w < CPA_WAYS; w++)
      begin
         if (hit_vec[w])
         begin
            hit_way = 2'(w);
         end
      end
   end

   // Register bus: control register, status register, zero for any other offset.
   always_comb
   begin
      ctl_d     = ctl_q;
      wb_ack_d  = i_wb_cyc & i_wb_stb & ~wb_ack_q;
      wb_dat_d  = 32'h0000_0000;
      purge_all = 1'b0;
      if (i_wb_cyc & i_wb_stb & ~wb_ack_q)
      begin
         if (i_wb_adr == CPA_OFS_CTL)
         begin
            if (i_wb_we & i_wb_sel[0])
            begin
               ctl_d     = i_wb_dat[7:0] & CPA_CTL_WMASK;
               purge_all = i_wb_dat[CPA_CTL_PRG];
            end
            wb_dat_d = {24'h00_0000, ctl_q};
         end
         else if (i_wb_adr == CPA_OFS_STAT)
         begin
            wb_dat_d = {26'h000_0000, cb_way_q, cb_bypass_q, cb_fill_q, cb_hit_q, state_q == CPA_ST_PURGE};
         end
      end
   end

   // Cache bus sequencer: lookups, purges and array accesses.
   always_comb
   begin
      state_d     = state_q;
      pur_addr_d  = pur_addr_q;
      cb_ack_d    = 1'b0;
      cb_err_d    = 1'b0;
      cb_rdata_d  = cb_rdata_q;
      cb_hit_d    = cb_hit_q;
      cb_fill_d   = cb_fill_q;
      cb_bypass_d = cb_bypass_q;
      cb_way_d    = cb_way_q;
      tag_we      = 1'b0;
      tag_way     = 2'h0;
      tag_idx     = look_idx;
      tag_wdata   = i_cb_addr[31-3:CPA_TAG_LSB];
      dat_we      = 4'h0;
      for (int w = 0; w < CPA_WAYS; w++)
      begin
         valid_d[w] = valid_q[w];
      end
      for (int e = 0; e < CPA_ENTRIES; e++)
      begin
         lru_d[e] = lru_q[e];
      end
      case (state_q)
         CPA_ST_PURGE:
         begin
            // Second cycle: drop the valid bit of the matching way only.
            if (|hit_vec)
            begin
               valid_d[hit_way][look_idx] = 1'b0;
            end
            cb_ack_d = 1'b1;
            state_d  = CPA_ST_IDLE;
         end
         default:
         begin
            if (take)
            begin
               cb_ack_d = 1'b1;
               if (i_cb_addr[31:29] == CPA_RGN_APURGE && i_cb_we)
               begin
                  // Nothing reaches memory; the compare runs in the next cycle.
                  pur_addr_d = i_cb_addr;
                  cb_ack_d   = 1'b0;
                  state_d    = CPA_ST_PURGE;
               end
               else if (i_cb_addr[31:29] == CPA_RGN_ADDRARR)
               begin
                  // Bits 28..10 carry the tag of a write, so only the region is decoded.
                  tag_way = {ctl_q[CPA_CTL_WSH], ctl_q[CPA_CTL_WSL]};
                  if (i_cb_size != CPA_SZ_LONG)
                  begin
                     cb_err_d = 1'b1;
                  end
                  else if (i_cb_we)
                  begin
                     tag_we  = 1'b1;
                     valid_d[tag_way][look_idx] = i_cb_addr[CPA_AVALID_BIT];
                     lru_d[look_idx] = i_cb_wdata[CPA_IDX_LSB +: CPA_LRU_W];
                  end
                  else
                  begin
                     cb_rdata_d = {3'h0, tag_mem[tag_way][look_idx], lru_q[look_idx], 1'b0,
                                   valid_q[tag_way][look_idx], 2'h0};
                  end
               end
               else if (i_cb_addr[31:29] == CPA_RGN_DATAARR && i_cb_addr[28:12] == 17'h0_0000)
               begin
                  // Served on the cache bus alone; works whatever the enable bit says.
                  if (i_cb_we)
                  begin
                     dat_we = cpa_lanes(i_cb_size, i_cb_addr[1:0]);
                  end
                  else
                  begin
                     cb_rdata_d = data_mem[dat_idx];
                  end
               end
               else if (i_cb_addr[31:29] == CPA_RGN_CACHED && ctl_q[CPA_CTL_EN])
               begin
                  // Fetches are looked up here regardless of register bus traffic.
                  cb_hit_d    = 1'b0;
                  cb_fill_d   = 1'b0;
                  cb_bypass_d = 1'b0;
                  cb_way_d    = hit_way;
                  if (i_cb_tset & ~i_cb_we)
                  begin
                     cb_bypass_d = 1'b1;
                  end
                  else if (|hit_vec)
                  begin
                     cb_hit_d = 1'b1;
                     lru_d[look_idx] = cpa_lru_upd(lru_q[look_idx], hit_way);
                  end
                  else if (~i_cb_we)
                  begin
                     if ((i_cb_ifetch & ctl_q[CPA_CTL_IFD]) | (~i_cb_ifetch & ctl_q[CPA_CTL_DFD]))
                     begin
                        cb_bypass_d = 1'b1;
                     end
                     else
                     begin
                        tag_way   = cpa_victim(lru_q[look_idx], ctl_q[CPA_CTL_TWM]);
                        tag_we    = 1'b1;
                        cb_fill_d = 1'b1;
                        cb_way_d  = tag_way;
                        valid_d[tag_way][look_idx] = 1'b1;
                        lru_d[look_idx] = cpa_lru_upd(lru_q[look_idx], tag_way);
                     end
                  end
               end
               else
               begin
                  cb_bypass_d = 1'b1;
                  cb_hit_d    = 1'b0;
                  cb_fill_d   = 1'b0;
               end
            end
         end
      endcase
      // A full purge overrides any same-cycle valid or LRU update; tag and data writes still happen.
      if (purge_all)
      begin
         for (int w = 0; w < CPA_WAYS; w++)
         begin
            valid_d[w] = '0;
         end
         for (int e = 0; e < CPA_ENTRIES; e++)
         begin
            lru_d[e] = '0;
         end
      end
   end

   // Control and answer registers; reset clears the enable bit.
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         state_q     <= CPA_ST_IDLE;
         pur_addr_q  <= 32'h0000_0000;
         cb_ack_q    <= 1'b0;
         cb_err_q    <= 1'b0;
         cb_rdata_q  <= 32'h0000_0000;
         cb_hit_q    <= 1'b0;
         cb_fill_q   <= 1'b0;
         cb_bypass_q <= 1'b0;
         cb_way_q    <= 2'h0;
         ctl_q       <= CPA_CTL_RST;
         wb_ack_q    <= 1'b0;
         wb_dat_q    <= 32'h0000_0000;
      end
      else
      begin
         state_q     <= state_d;
         pur_addr_q  <= pur_addr_d;
         cb_ack_q    <= cb_ack_d;
         cb_err_q    <= cb_err_d;
         cb_rdata_q  <= cb_rdata_d;
         cb_hit_q    <= cb_hit_d;
         cb_fill_q   <= cb_fill_d;
         cb_bypass_q <= cb_bypass_d;
         cb_way_q    <= cb_way_d;
         ctl_q       <= ctl_d;
         wb_ack_q    <= wb_ack_d;
         wb_dat_q    <= wb_dat_d;
      end
   end

   // Valid and LRU state; deliberately outside reset.
   always_ff @(posedge i_core_clk)
   begin
      for (int w = 0; w < CPA_WAYS; w++)
      begin
         valid_q[w] <= valid_d[w];
      end
      for (int e = 0; e < CPA_ENTRIES; e++)
      begin
         lru_q[e] <= lru_d[e];
      end
   end

   // Tag array write port.
   always_ff @(posedge i_core_clk)
   begin
      if (tag_we)
      begin
         tag_mem[tag_way][tag_idx] <= tag_wdata;
      end
   end

   // Data array write port, one enable per byte lane; one process owns the whole array.
   always_ff @(posedge i_core_clk)
   begin
      for (int l = 0; l < 4; l++)
      begin
         if (dat_we[l])
         begin
            data_mem[dat_idx][l*8 +: 8] <= i_cb_wdata[l*8 +: 8];
         end
      end
   end

   assign o_wb_dat    = wb_dat_q;
   assign o_wb_ack    = wb_ack_q;
   assign o_cb_ack    = cb_ack_q;
   assign o_cb_err    = cb_err_q;
   assign o_cb_rdata  = cb_rdata_q;
   assign o_cb_hit    = cb_hit_q;
   assign o_cb_fill   = cb_fill_q;
   assign o_cb_bypass = cb_bypass_q;
   assign o_cb_way    = cb_way_q;
   assign o_cache_en  = ctl_q[CPA_CTL_EN];
   assign o_two_way   = ctl_q[CPA_CTL_TWM];

endmodule

// ### verilog/cpa_pkg.sv
/*
 * Constants for the cache maintenance and array access block: address regions,
 * control register fields, bus offsets, array layouts and the state encoding.
 * Assumes a 32-bit cache bus from the CPU core and a classic Wishbone register bus.
 */
package cpa_pkg;

   // Array geometry.
   localparam int unsigned CPA_WAYS     = 4;
   localparam int unsigned CPA_ENTRIES  = 64;
   localparam int unsigned CPA_WAYWORDS = 256;
   localparam int unsigned CPA_TAG_W    = 19;
   localparam int unsigned CPA_LRU_W    = 6;

   // Cache bus regions, taken from address bits 31..29.
   localparam logic [2:0] CPA_RGN_CACHED  = 3'h0;
   localparam logic [2:0] CPA_RGN_APURGE  = 3'h2;
   localparam logic [2:0] CPA_RGN_ADDRARR = 3'h3;
   localparam logic [2:0] CPA_RGN_DATAARR = 3'h6;

   // Address bit positions on the cache bus.
   localparam int unsigned CPA_TAG_LSB   = 10;
   localparam int unsigned CPA_IDX_LSB   = 4;
   localparam int unsigned CPA_AVALID_BIT = 2;

   // Control register field positions.
   localparam int unsigned CPA_CTL_EN  = 0;
   localparam int unsigned CPA_CTL_IFD = 1;
   localparam int unsigned CPA_CTL_DFD = 2;
   localparam int unsigned CPA_CTL_TWM = 3;
   localparam int unsigned CPA_CTL_PRG = 4;
   localparam int unsigned CPA_CTL_WSL = 6;
   localparam int unsigned CPA_CTL_WSH = 7;
   localparam logic [7:0]  CPA_CTL_RST = 8'h00;
   localparam logic [7:0]  CPA_CTL_WMASK = 8'hCF;

   // Wishbone register byte offsets.
   localparam logic [3:0] CPA_OFS_CTL  = 4'h0;
   localparam logic [3:0] CPA_OFS_STAT = 4'h4;

   // Access sizes on the cache bus.
   localparam logic [1:0] CPA_SZ_BYTE = 2'h0;
   localparam logic [1:0] CPA_SZ_WORD = 2'h1;
   localparam logic [1:0] CPA_SZ_LONG = 2'h2;

   // Sequencer states, Gray coded.
   typedef enum logic [0:0] {
      CPA_ST_IDLE  = 1'b0,
      CPA_ST_PURGE = 1'b1
   } cpa_state_t;

endpackage
